// ---- shared/sfd_pkg.sv ----
// package: constants, register map and carrier types of the flag byte and log block
package sfd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LOG_DEPTH = 50;
  localparam int LOG_KEEP = 10;
  localparam int RET_LIMIT = 2048;
  localparam int RET_W = 12;
  localparam logic [15:0] FIRST_FLAG_BYTE = 16'h0000;
  // timing
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_PER_SEC = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_SEC;
  localparam int SEC_PERIOD_S = 1;
  localparam int CYC_PER_SEC = SEC_PERIOD_S * CLK_HZ;
  // clock flag half periods, bit 7 slowest (0.5 Hz) down to bit 0 fastest (10 Hz)
  localparam int HALF_MS_B7 = 1000;
  localparam int HALF_MS_B6 = 800;
  localparam int HALF_MS_B5 = 500;
  localparam int HALF_MS_B4 = 400;
  localparam int HALF_MS_B3 = 250;
  localparam int HALF_MS_B2 = 200;
  localparam int HALF_MS_B1 = 100;
  localparam int HALF_MS_B0 = 50;
  localparam logic [255:0] CLK_HALF_CYC = {
    32'(HALF_MS_B7 * CYC_PER_MS), 32'(HALF_MS_B6 * CYC_PER_MS),
    32'(HALF_MS_B5 * CYC_PER_MS), 32'(HALF_MS_B4 * CYC_PER_MS),
    32'(HALF_MS_B3 * CYC_PER_MS), 32'(HALF_MS_B2 * CYC_PER_MS),
    32'(HALF_MS_B1 * CYC_PER_MS), 32'(HALF_MS_B0 * CYC_PER_MS)};
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAG_ADDR = 8'h04;
  localparam logic [7:0] REG_TZ = 8'h08;
  localparam logic [7:0] REG_DST = 8'h0c;
  localparam logic [7:0] REG_UTC = 8'h10;
  localparam logic [7:0] REG_LOCAL = 8'h14;
  localparam logic [7:0] REG_RET_CFG = 8'h18;
  localparam logic [7:0] REG_LOG_SEL = 8'h1c;
  localparam logic [7:0] REG_LOG_TIME = 8'h20;
  localparam logic [7:0] REG_LOG_INFO = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_IRQ_STAT = 8'h2c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h30;
  // field positions
  localparam int CTRL_SYS_EN = 0;
  localparam int CTRL_CLK_EN = 1;
  localparam int CTRL_DST_EN = 2;
  localparam int SYS_FIRST = 0;
  localparam int SYS_DIAG = 1;
  localparam int SYS_HIGH = 2;
  localparam int SYS_LOW = 3;
  localparam int IRQ_LOG = 0;
  localparam int IRQ_REFUSE = 1;
  localparam int IRQ_RUN = 2;
  localparam int IRQ_STOP = 3;
  localparam int IRQ_W = 4;
  // log codes for state changes
  localparam logic [7:0] CAT_STATE = 8'h01;
  localparam logic [15:0] DESC_PWRUP = 16'h0001;
  localparam logic [15:0] DESC_STOP = 16'h0002;
  localparam logic [15:0] DESC_RUN = 16'h0003;
  typedef enum logic [1:0] {
    MD_STOP = 2'b00, MD_START = 2'b01, MD_RUN = 2'b11, MD_SAVE = 2'b10
  } sfd_mode_t;
  typedef struct packed {
    logic [31:0] stamp;
    logic [7:0] cat;
    logic [15:0] desc;
  } sfd_entry_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sfd_bus_t;
  typedef struct packed {
    logic valid;
    logic [7:0] cat;
    logic [15:0] desc;
  } sfd_diag_t;
  typedef struct packed {
    logic valid;
    sfd_entry_t entry;
  } sfd_nv_t;
  typedef struct packed {
    logic sys_en;
    logic [15:0] sys_addr;
    logic [7:0] sys_byte;
    logic clk_en;
    logic [15:0] clk_addr;
    logic [7:0] clk_byte;
  } sfd_flags_t;
endpackage

// ---- rtl/sfd_logmem.sv ----
// log memory with registered read data
`timescale 1ns/1ns
module sfd_logmem #(
  parameter int W = 56,
  parameter int D = 50,
  parameter int AW = 6
) (
  // clock
  input wire logic ref_clk,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [D];

  if (D > (1 << AW)) begin : g_chk
    $error("address width too small for depth");
  end

  // no reset: contents are data, read data is sampled every enabled cycle
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // sfd_logmem

// ---- rtl/sfd_clkflag.sv ----
// eight square wave flags, counting while run is high and held while it is low, cleared to zero while init is high
`timescale 1ns/1ns
module sfd_clkflag #(
  parameter logic [255:0] HALF = sfd_pkg::CLK_HALF_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // control
  input wire logic init,
  input wire logic run,
  // flags
  output logic [7:0] q
);
  import sfd_pkg::*;
  typedef struct packed {
    logic [7:0][31:0] cnt;
    logic [7:0] q;
  } sfd_ck_t;
  sfd_ck_t s_reg, s_next;
  logic [7:0][31:0] cnt_nx;
  logic [7:0] q_nx;

  // per bit divider, half period taken from the table
  for (genvar i = 0; i < 8; i++) begin : g_bit
    if (HALF[i*32 +: 32] == 32'h0) begin : g_chk
      $error("clock flag half period must be nonzero");
    end
    logic wrap;
    assign wrap = (s_reg.cnt[i] == HALF[i*32 +: 32] - 32'h1);
    assign cnt_nx[i] = init ? 32'h0 : (!run ? s_reg.cnt[i] :
                       (wrap ? 32'h0 : s_reg.cnt[i] + 32'h1));
    assign q_nx[i] = init ? 1'b0 : ((run && wrap) ? ~s_reg.q[i] : s_reg.q[i]);
  end

  // collect next state
  always_comb begin
    s_next = s_reg;
    s_next.cnt = cnt_nx;
    s_next.q = q_nx;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
  assign q = s_reg.q;

  a_init_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && init) |=> (q == 8'h00)) else $error("flags not cleared at init");
  a_hold_stop: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ce && !run && !init) |=> $stable(q)) else $error("flags moved while stopped");
endmodule // sfd_clkflag

// ---- rtl/sfd_top.sv ----
// system and clock flag bytes, diagnostic log, retain control and time of day
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module sfd_top #(
  parameter int CYC_SEC = sfd_pkg::CYC_PER_SEC,
  parameter logic [255:0] CLK_HALF = sfd_pkg::CLK_HALF_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire sfd_pkg::sfd_bus_t bus,
  output logic [sfd_pkg::DATA_W-1:0] rdata,
  output logic irq,
  // controller sequencing
  input wire logic go_run,
  input wire logic go_stop,
  input wire logic startup_done,
  input wire logic scan_end,
  input wire sfd_pkg::sfd_diag_t diag,
  // power and retention
  input wire logic pwr_fail,
  input wire sfd_pkg::sfd_nv_t nv_load,
  output sfd_pkg::sfd_nv_t nv_save,
  output logic ret_save,
  output logic ret_restore,
  output logic [sfd_pkg::RET_W-1:0] ret_len,
  // flag bytes toward bit memory
  output sfd_pkg::sfd_flags_t flags,
  output sfd_pkg::sfd_mode_t mode
);
  import sfd_pkg::*;

  localparam int PW = 6;
  localparam logic [PW-1:0] LAST_IDX = PW'(LOG_DEPTH - 1);
  localparam logic [PW-1:0] FULL_CNT = PW'(LOG_DEPTH);
  localparam logic [3:0] KEEP_CNT = 4'(LOG_KEEP);

  if (CYC_SEC < 2) begin : g_chk
    $error("second tick count too small");
  end

  typedef struct packed {
    sfd_mode_t mode;
    logic pwr_up_done;
    logic first_done;
    logic first_scan;
    logic diag_pend;
    logic diag_bit;
    logic [2:0] ctrl;
    logic [15:0] sys_addr;
    logic [15:0] clk_addr;
    logic [31:0] tz;
    logic [31:0] dst;
    logic [31:0] utc;
    logic [31:0] tick;
    logic [RET_W-1:0] m_bytes;
    logic [RET_W-1:0] db_bytes;
    logic [PW-1:0] sel;
    logic [PW-1:0] wptr;
    logic [PW-1:0] cnt;
    logic st_pend;
    logic [15:0] st_desc;
    logic dg_pend;
    logic [23:0] dg;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [DATA_W-1:0] rdata;
    logic [3:0] save_k;
    logic [3:0] save_n;
    logic save_rd;
    logic save_done;
    sfd_nv_t nv;
    logic ret_save;
    logic ret_restore;
    sfd_flags_t flags;
  } sfd_st_t;

  sfd_st_t s_reg, s_next;
  logic we;
  logic [PW-1:0] raddr;
  sfd_entry_t wentry, rentry;
  logic clk_init, clk_run;
  logic [7:0] clk_q;
  logic [31:0] local_t;
  logic [PW-1:0] newest;

  // ring position k back from the newest entry
  function automatic logic [PW-1:0] back_idx(input logic [PW-1:0] top, input logic [PW-1:0] k);
    logic [PW:0] t;
    t = {1'b0, top} - {1'b0, k};
    if (t[PW]) begin
      t = t + (PW+1)'(LOG_DEPTH);
    end
    return t[PW-1:0];
  endfunction

  sfd_logmem #(.W($bits(sfd_entry_t)), .D(LOG_DEPTH), .AW(PW)) u_mem (
    .ref_clk(ref_clk),
    .ce(ce),
    .we(we),
    .waddr(s_reg.wptr),
    .wdata(wentry),
    .raddr(raddr),
    .rdata(rentry)
  );

  sfd_clkflag #(.HALF(CLK_HALF)) u_clk (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .init(clk_init),
    .run(clk_run),
    .q(clk_q)
  );

  // local time is universal time plus zone and optional summer offsets
  assign local_t = s_reg.utc + s_reg.tz + (s_reg.ctrl[CTRL_DST_EN] ? s_reg.dst : 32'h0);
  assign newest = (s_reg.wptr == '0) ? LAST_IDX : s_reg.wptr - PW'(1);
  assign clk_init = (s_reg.mode == MD_STOP) && go_run;
  assign clk_run = (s_reg.mode == MD_START) || (s_reg.mode == MD_RUN);

  // log write selection: reload from the store first, then state changes, then diagnostics
  always_comb begin
    we = 1'b0;
    wentry = '0;
    if (s_reg.mode != MD_SAVE) begin
      if (nv_load.valid) begin
        we = 1'b1;
        wentry = nv_load.entry;
      end else if (s_reg.st_pend) begin
        we = 1'b1;
        wentry = '{stamp: s_reg.utc, cat: CAT_STATE, desc: s_reg.st_desc};
      end else if (s_reg.dg_pend) begin
        we = 1'b1;
        wentry = '{stamp: s_reg.utc, cat: s_reg.dg[23:16], desc: s_reg.dg[15:0]};
      end
    end
  end

  // read address: save walk while saving, else the software selected entry
  assign raddr = (s_reg.mode == MD_SAVE) ? back_idx(newest, PW'(s_reg.save_k))
                                         : back_idx(newest, s_reg.sel);

  // next state
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [RET_W:0] ret_sum;
    logic dg_logged;
    ev = '0;
    ret_sum = '0;
    dg_logged = we && !nv_load.valid && !s_reg.st_pend;
    s_next = s_reg;
    s_next.ret_save = 1'b0;
    s_next.ret_restore = 1'b0;
    s_next.nv.valid = 1'b0;
    s_next.rdata = '0;
    // seconds of universal time
    s_next.tick = (s_reg.tick == 32'(CYC_SEC - 1)) ? 32'h0 : s_reg.tick + 32'h1;
    if (s_reg.tick == 32'(CYC_SEC - 1)) begin
      s_next.utc = s_reg.utc + 32'h1;
    end
    // first cycle after reset is power return
    if (!s_reg.pwr_up_done) begin
      s_next.pwr_up_done = 1'b1;
      s_next.ret_restore = 1'b1;
      s_next.st_pend = 1'b1;
      s_next.st_desc = DESC_PWRUP;
    end
    // ring buffer write, overwriting the oldest once full
    if (we) begin
      s_next.wptr = (s_reg.wptr == LAST_IDX) ? '0 : s_reg.wptr + PW'(1);
      s_next.cnt = (s_reg.cnt == FULL_CNT) ? FULL_CNT : s_reg.cnt + PW'(1);
      ev[IRQ_LOG] = 1'b1;
      if (!nv_load.valid && s_reg.st_pend) begin
        s_next.st_pend = 1'b0;
      end
      if (dg_logged) begin
        s_next.dg_pend = 1'b0;
      end
    end
    // scan boundary: first scan ends, diagnostic-changed shows one scan
    if (s_reg.mode == MD_RUN && scan_end) begin
      s_next.first_scan = 1'b0;
      s_next.first_done = 1'b1;
      s_next.diag_bit = s_reg.diag_pend;
      s_next.diag_pend = 1'b0;
    end
    // only events logged after the first pass raise diagnostic-changed
    if (dg_logged && s_reg.first_done) begin
      s_next.diag_pend = 1'b1;
    end
    // new diagnostic event waits in a one deep slot
    if (diag.valid && s_reg.mode != MD_SAVE) begin
      s_next.dg_pend = 1'b1;
      s_next.dg = {diag.cat, diag.desc};
    end
    // operating state sequence
    case (s_reg.mode)
      MD_STOP: begin
        if (go_run) begin
          s_next.mode = MD_START;
          s_next.first_scan = 1'b0;
          s_next.first_done = 1'b0;
          s_next.diag_pend = 1'b0;
          s_next.diag_bit = 1'b0;
        end
      end
      MD_START: begin
        if (go_stop) begin
          s_next.mode = MD_STOP;
          s_next.st_pend = 1'b1;
          s_next.st_desc = DESC_STOP;
          ev[IRQ_STOP] = 1'b1;
        end else if (startup_done) begin
          s_next.mode = MD_RUN;
          s_next.first_scan = 1'b1;
          s_next.st_pend = 1'b1;
          s_next.st_desc = DESC_RUN;
          ev[IRQ_RUN] = 1'b1;
        end
      end
      MD_RUN: begin
        if (go_stop) begin
          s_next.mode = MD_STOP;
          s_next.first_scan = 1'b0;
          s_next.diag_bit = 1'b0;
          s_next.st_pend = 1'b1;
          s_next.st_desc = DESC_STOP;
          ev[IRQ_STOP] = 1'b1;
        end
      end
      MD_SAVE: begin
        // stream the newest entries out, then hand off the retained range
        s_next.save_rd = 1'b0;
        if (s_reg.save_k != s_reg.save_n) begin
          s_next.save_k = s_reg.save_k + 4'h1;
          s_next.save_rd = 1'b1;
        end else if (!s_reg.save_rd && !s_reg.save_done) begin
          s_next.save_done = 1'b1;
          s_next.ret_save = 1'b1;
        end
        s_next.nv.valid = s_reg.save_rd;
        s_next.nv.entry = rentry;
      end
      default: s_next.mode = MD_STOP;
    endcase
    // power failure overrides the state sequence and never returns without reset
    if (pwr_fail && s_reg.mode != MD_SAVE) begin
      s_next.mode = MD_SAVE;
      s_next.save_k = 4'h0;
      s_next.save_n = (s_reg.cnt > PW'(LOG_KEEP)) ? KEEP_CNT : s_reg.cnt[3:0];
      s_next.save_rd = 1'b0;
      s_next.save_done = 1'b0;
    end
    // register writes
    if (bus.wr) begin
      case (bus.addr)
        REG_CTRL: s_next.ctrl = bus.wdata[2:0];
        REG_FLAG_ADDR: {s_next.clk_addr, s_next.sys_addr} = bus.wdata;
        REG_TZ: s_next.tz = bus.wdata;
        REG_DST: s_next.dst = bus.wdata;
        REG_UTC: s_next.utc = bus.wdata;
        REG_RET_CFG: begin
          ret_sum = {1'b0, bus.wdata[RET_W-1:0]} + {1'b0, bus.wdata[RET_W+15:16]};
          if (ret_sum > (RET_W+1)'(RET_LIMIT)) begin
            ev[IRQ_REFUSE] = 1'b1;
          end else begin
            s_next.m_bytes = bus.wdata[RET_W-1:0];
            s_next.db_bytes = bus.wdata[RET_W+15:16];
          end
        end
        REG_LOG_SEL: s_next.sel = bus.wdata[PW-1:0];
        REG_IRQ_MASK: s_next.irq_mask = bus.wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // register reads, answered in the next cycle
    if (bus.rd) begin
      case (bus.addr)
        REG_CTRL: s_next.rdata = 32'(s_reg.ctrl);
        REG_FLAG_ADDR: s_next.rdata = {s_reg.clk_addr, s_reg.sys_addr};
        REG_TZ: s_next.rdata = s_reg.tz;
        REG_DST: s_next.rdata = s_reg.dst;
        REG_UTC: s_next.rdata = s_reg.utc;
        REG_LOCAL: s_next.rdata = local_t;
        REG_RET_CFG: s_next.rdata = {4'h0, s_reg.db_bytes, 4'h0, s_reg.m_bytes};
        REG_LOG_SEL: s_next.rdata = 32'(s_reg.sel);
        REG_LOG_TIME: s_next.rdata = rentry.stamp;
        REG_LOG_INFO: s_next.rdata = {8'h00, rentry.desc, rentry.cat};
        REG_STATUS: s_next.rdata = {22'h0, s_reg.mode, 2'h0, s_reg.cnt};
        REG_IRQ_STAT: s_next.rdata = 32'(s_reg.irq_stat);
        REG_IRQ_MASK: s_next.rdata = 32'(s_reg.irq_mask);
        default: s_next.rdata = '0;
      endcase
    end
    // sticky status: a read clears, a new event in the same cycle wins
    s_next.irq_stat = ((bus.rd && bus.addr == REG_IRQ_STAT) ? '0 : s_reg.irq_stat) | ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    // flag bytes; not write protected, the bit memory may overwrite them
    s_next.flags.sys_en = s_reg.ctrl[CTRL_SYS_EN];
    s_next.flags.sys_addr = s_reg.sys_addr;
    s_next.flags.sys_byte = '0;
    s_next.flags.sys_byte[SYS_FIRST] = s_next.first_scan;
    s_next.flags.sys_byte[SYS_DIAG] = s_next.diag_bit;
    s_next.flags.sys_byte[SYS_HIGH] = 1'b1;
    s_next.flags.sys_byte[SYS_LOW] = 1'b0;
    s_next.flags.clk_en = s_reg.ctrl[CTRL_CLK_EN];
    s_next.flags.clk_addr = s_reg.clk_addr;
    s_next.flags.clk_byte = clk_q;
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign rdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign nv_save = s_reg.nv;
  assign ret_save = s_reg.ret_save;
  assign ret_restore = s_reg.ret_restore;
  assign ret_len = s_reg.m_bytes; // range starts at FIRST_FLAG_BYTE
  assign flags = s_reg.flags;
  assign mode = s_reg.mode;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_low_bit_zero: assert property (!flags.sys_byte[SYS_LOW])
    else $error("constant low bit set");
  a_high_bit_one: assert property (s_reg.pwr_up_done |-> flags.sys_byte[SYS_HIGH])
    else $error("constant high bit clear");
  a_log_bounded: assert property (s_reg.cnt <= FULL_CNT)
    else $error("log count above depth");
  a_full_wrap: assert property (ce && we && s_reg.cnt == FULL_CNT |=> s_reg.cnt == FULL_CNT)
    else $error("full log count changed");
  a_save_keep: assert property (s_reg.save_n <= KEEP_CNT)
    else $error("too many entries saved");
  a_first_ends: assert property (ce && s_reg.mode == MD_RUN && scan_end && !go_stop
    && !pwr_fail |=> !s_reg.first_scan && s_reg.first_done)
    else $error("first scan bit not cleared");
  a_diag_scan: assert property ($rose(s_reg.diag_bit) |-> $past(scan_end && ce)
    && $past(s_reg.first_done))
    else $error("diag changed raised off a scan end");
  a_ret_refuse: assert property (ce && bus.wr && bus.addr == REG_RET_CFG
    && ({1'b0, bus.wdata[RET_W-1:0]} + {1'b0, bus.wdata[RET_W+15:16]}) > 13'(RET_LIMIT)
    |=> $stable(s_reg.m_bytes) && s_reg.irq_stat[IRQ_REFUSE])
    else $error("oversize retain setting accepted");
  a_run_logged: assert property (ce && s_reg.mode == MD_START && startup_done && !go_stop
    && !pwr_fail |=> s_reg.st_pend && s_reg.st_desc == DESC_RUN)
    else $error("run entry not queued for the log");
endmodule // sfd_top

// ---- verification/sfd_tb.sv ----
// self-checking bench for the flag bytes, diagnostic log, retain and time-of-day block
`timescale 1ns/1ns
module tb;
  import sfd_pkg::*;
  // short half periods, bit 0 fastest; every one divides the 80 cycle window
  localparam logic [255:0] HALF = {32'd40, 32'd20, 32'd16, 32'd10, 32'd8, 32'd5, 32'd4, 32'd2};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  sfd_bus_t bus = '0;
  sfd_diag_t diag = '0;
  sfd_nv_t nv = '0;
  logic ce = 1'b1;
  logic [4:0] ctl = '0; // pwr_fail, go_run, go_stop, startup_done, scan_end
  logic [DATA_W-1:0] rdata;
  logic irq;
  logic ret_save;
  logic ret_restore;
  logic [RET_W-1:0] ret_len;
  sfd_nv_t nv_save;
  sfd_flags_t flags;
  sfd_mode_t mode;
  logic [31:0] d;
  int bad_count = 0;
  int tests_run = 0;

  // seconds divider kept long so the time counter stays still during the run
  sfd_top #(.CYC_SEC(1000000), .CLK_HALF(HALF)) sfd_top_inst (.ref_clk(ref_clk), .nrst(nrst),
    .ce(ce), .bus(bus), .rdata(rdata), .irq(irq), .go_run(ctl[3]), .go_stop(ctl[2]),
    .startup_done(ctl[1]), .scan_end(ctl[0]), .diag(diag), .pwr_fail(ctl[4]), .nv_load(nv),
    .nv_save(nv_save), .ret_save(ret_save), .ret_restore(ret_restore), .ret_len(ret_len),
    .flags(flags), .mode(mode));

  // shared compare, counts every check
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // register write: one strobe cycle
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  // register read: data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse(logic [4:0] m);
    @(posedge ref_clk);
    ctl <= m;
    @(posedge ref_clk);
    ctl <= '0;
  endtask
  task automatic ev(logic [7:0] c, logic [15:0] s);
    @(posedge ref_clk);
    diag <= '{valid: 1'b1, cat: c, desc: s};
    @(posedge ref_clk);
    diag.valid <= 1'b0;
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // startup: constant bits, first scan, a startup diag that must stay hidden
  task automatic t_startup();
    wr(REG_IRQ_MASK, 32'h0000_000f);
    wr(REG_CTRL, 32'h0000_0003);
    idle(3);
    chk("sys_byte", 32'h04, flags.sys_byte);
    pulse(5'b01000);
    idle(2);
    chk("mode", MD_START, mode);
    ev(8'h22, 16'h1234);
    idle(4);
    pulse(5'b00010);
    idle(4);
    chk("sys_byte", 32'h05, flags.sys_byte);
    chk("irq", 32'h1, irq);
    wr(REG_LOG_SEL, 32'h0);
    idle(2);
    rd(REG_LOG_INFO);
    chk("log_info", 32'h0003_01, d);
    rd(REG_IRQ_STAT);
    chk("irq_stat", 32'h5, d);
    rd(REG_IRQ_STAT);
    chk("irq_stat", 32'h0, d);
    chk("irq", 32'h0, irq);
    pulse(5'b00001);
    idle(4);
    chk("sys_byte", 32'h04, flags.sys_byte);
  endtask
  // run: a diag shows for exactly one scan, and is logged
  task automatic t_run();
    ev(8'h22, 16'h0abc);
    idle(3);
    chk("sys_byte", 32'h04, flags.sys_byte);
    pulse(5'b00001);
    idle(3);
    chk("sys_byte", 32'h06, flags.sys_byte);
    pulse(5'b00001);
    idle(3);
    chk("sys_byte", 32'h04, flags.sys_byte);
    wr(REG_LOG_SEL, 32'h0);
    idle(2);
    rd(REG_LOG_INFO);
    chk("log_info", 32'h0abc_22, d);
  endtask
  // each clock flag toggles 80/half times in an 80 cycle window, whatever the phase
  task automatic t_clock();
    logic [7:0] p;
    int n [8];
    n = '{default: 0};
    p = flags.clk_byte;
    repeat (80) begin
      idle(1);
      for (int k = 0; k < 8; k++) if (flags.clk_byte[k] !== p[k]) n[k]++;
      p = flags.clk_byte;
    end
    for (int k = 0; k < 8; k++) chk("clk_toggles", 80 / HALF[k*32 +: 32], n[k]);
  endtask
  // retained length: over-limit refused, exact limit taken
  task automatic t_retain();
    wr(REG_RET_CFG, 32'h07f0_0011);
    idle(3);
    chk("ret_len", 32'h0, ret_len);
    rd(REG_IRQ_STAT);
    chk("refused", 32'h1, d[IRQ_REFUSE]);
    wr(REG_RET_CFG, 32'h07f0_0010);
    idle(3);
    chk("ret_len", 32'h10, ret_len);
  endtask
  // local time with and without the summer offset, plus an unmapped read
  task automatic t_local();
    wr(REG_UTC, 32'd100);
    wr(REG_TZ, 32'd3600);
    wr(REG_DST, 32'd60);
    rd(REG_LOCAL);
    chk("local", 32'd3700, d);
    wr(REG_CTRL, 32'h0000_0007);
    rd(REG_LOCAL);
    chk("local", 32'd3760, d);
    rd(8'hfc);
    chk("unmapped", 32'h0, d);
  endtask
  // overfill the log, then lose power and watch the save sequence
  task automatic t_fill_save();
    int n;
    int s;
    logic [15:0] f;
    n = 0;
    s = 0;
    f = '0;
    for (int i = 0; i < 55; i++) ev(8'h33, 16'(i));
    idle(3);
    rd(REG_STATUS);
    chk("count", 32'd50, d[5:0]);
    wr(REG_LOG_SEL, 32'd49);
    idle(2);
    rd(REG_LOG_INFO);
    chk("oldest", 32'h0005_33, d);
    wr(REG_LOG_SEL, 32'h0);
    idle(2);
    rd(REG_LOG_TIME);
    chk("stamp", 32'd100, d);
    pulse(5'b10000);
    repeat (40) begin
      idle(1);
      if (nv_save.valid === 1'b1 && n == 0) f = nv_save.entry.desc;
      if (nv_save.valid === 1'b1) n++;
      if (ret_save === 1'b1) s++;
    end
    chk("saved", 32'd10, n);
    chk("newest_saved", 32'd54, f);
    chk("ret_save", 32'd1, s);
    chk("mode", MD_SAVE, mode);
  endtask
  // second power cycle: reload, flag placement, clock freeze, stop entry and held flags
  task automatic t_restart();
    int r;
    logic [7:0] q;
    r = 0;
    @(posedge ref_clk);
    nrst <= 1'b0;
    idle(3);
    chk("reset_mode", MD_STOP, mode);
    chk("reset_byte", 32'h0, flags.sys_byte);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) begin
      idle(1);
      if (ret_restore === 1'b1) r++;
    end
    chk("ret_restore", 32'd1, r);
    // a saved entry handed back after power return
    @(posedge ref_clk);
    nv <= '{valid: 1'b1, entry: '{stamp: 32'd7, cat: 8'h44, desc: 16'h0777}};
    @(posedge ref_clk);
    nv.valid <= 1'b0;
    idle(2);
    rd(REG_LOG_INFO);
    chk("reload_info", 32'h0007_7744, d);
    rd(REG_LOG_TIME);
    chk("reload_stamp", 32'd7, d);
    rd(REG_STATUS);
    chk("count", 32'd2, d[5:0]);
    wr(REG_LOG_SEL, 32'h1);
    idle(2);
    rd(REG_LOG_INFO);
    chk("pwrup_info", 32'h0001_01, d);
    // flag byte placement and enables
    wr(REG_FLAG_ADDR, 32'h0020_0010);
    wr(REG_CTRL, 32'h0000_0003);
    idle(2);
    chk("sys_addr", 32'h10, flags.sys_addr);
    chk("clk_addr", 32'h20, flags.clk_addr);
    chk("flag_en", 32'h3, {flags.clk_en, flags.sys_en});
    pulse(5'b01000);
    pulse(5'b00010);
    idle(2);
    // clock enable low freezes the running dividers
    @(posedge ref_clk);
    ce <= 1'b0;
    idle(1);
    q = flags.clk_byte;
    idle(4);
    chk("frozen", q, flags.clk_byte);
    @(posedge ref_clk);
    ce <= 1'b1;
    // stop: logged, flagged, and the clock flags hold
    pulse(5'b00100);
    idle(3);
    chk("mode", MD_STOP, mode);
    q = flags.clk_byte;
    wr(REG_LOG_SEL, 32'h0);
    idle(3);
    chk("held", q, flags.clk_byte);
    rd(REG_LOG_INFO);
    chk("stop_info", 32'h0002_01, d);
    rd(REG_IRQ_STAT);
    chk("stop_irq", 32'h1, d[IRQ_STOP]);
  endtask

  // clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end
  // main sequence
  initial begin
    int r;
    r = 0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) begin
      idle(1);
      if (ret_restore === 1'b1) r++;
    end
    chk("ret_restore", 32'd1, r);
    t_startup();
    t_run();
    t_clock();
    t_retain();
    t_local();
    t_fill_save();
    t_restart();
    conclude();
  end
endmodule // tb
